// ===== shared/exc_entry_pkg.sv
// Functional notes
// - Run-mode exception is taken only while config enable field (bits 8-9) equals 01.
// - Raise run-mode exception on address compare, branch target compare, or single-step trace.
// - Clearing the trace enable stops trace exceptions from the very next instruction.
// - Run-mode and trace exceptions vector to offset 02000 hex.
// - Run-mode exception saves the causing instruction address as saved program counter.
// - Run-mode exception copies all 32 machine state bits into the saved state register.
// - Debug run mode comes from config bits 1 to 3.
// - Modes: 000 normal, 010 limited, 100 step, 110 full, 111 branch; others undefined.
// - Address compare modes break when breakpoint equals queue bottom slot address.
// - After run-mode or trace exception, fetch resumes at base plus 02000 hex.
// - Later revisions recognise external interrupt held at least two clock cycles.
// - Later revisions ignore an external interrupt shorter than one clock cycle.
// - Any exception taken, including system call and program trap, cancels the reservation.
// - Another master storing within the reserved 32-byte sector cancels the reservation.
// - Alignment exception loads fault data address with the faulting effective address.
// - Reserve, conditional-store or string-compare to I/O segment raises data access exception.
// - Such an I/O segment access crossing a segment boundary raises alignment instead.
// - Loads and update forms to I/O segments write the target register despite exceptions.
// - Instruction fetch from I/O segment fault clears saved state bits 0 to 15.
// - Saved program counter points at the completing instruction or a later completing one.
// - Fetch forbidden by key and protection bits raises instruction access fault, fetches nothing.
package exc_entry_pkg;
   // Bit numbering is big-endian: bit 0 is the most significant bit of a word
   localparam int WORD_W = 32;
   localparam int CFG_EN_HI = 31 - 8;
   localparam int CFG_EN_LO = 31 - 9;
   localparam int CFG_MODE_HI = 31 - 1;
   localparam int CFG_MODE_LO = 31 - 3;
   localparam logic [1:0] RUN_EXC_ENABLED = 2'h1;
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_LIMITED_IA = 3'h2;
   localparam logic [2:0] MODE_STEP = 3'h4;
   localparam logic [2:0] MODE_FULL_IA = 3'h6;
   localparam logic [2:0] MODE_BRANCH = 3'h7;
   // Machine state bit positions (big-endian index converted)
   localparam int MS_EXT_EN = 31 - 16;
   localparam int MS_PRIV = 31 - 17;
   localparam int MS_FLT_AVAIL = 31 - 18;
   localparam int MS_MCHK_EN = 31 - 19;
   localparam int MS_FEX_LO = 31 - 20;
   localparam int MS_STEP_EN = 31 - 21;
   localparam int MS_FEX_HI = 31 - 23;
   localparam int MS_VEC_HI = 31 - 25;
   localparam int MS_ITRANS = 31 - 26;
   localparam int MS_DTRANS = 31 - 27;
   localparam logic [31:0] ENTRY_CLEAR_MASK = 32'h0000_FF00 & ~32'h0000_0000
      | (32'h1 << MS_EXT_EN);
   localparam logic [31:0] VEC_RUN_MODE = 32'h0000_2000;
   localparam logic [31:0] VEC_BASE_HI = 32'hFFF0_0000;
   localparam logic [31:0] VEC_BASE_LO = 32'h0000_0000;
   localparam logic [31:0] VEC_ALIGN = 32'h0000_0600;
   localparam logic [31:0] VEC_DSI = 32'h0000_0300;
   localparam logic [31:0] VEC_ISI = 32'h0000_0400;
   localparam logic [31:0] VEC_EXT = 32'h0000_0500;
   localparam logic [31:0] VEC_OTHER = 32'h0000_0700;
   localparam logic [31:0] SECTOR_MASK = 32'hFFFF_FFE0;
   localparam logic [31:0] SAVE_HI_CLEAR = 32'h0000_FFFF;
   // Arbitrary neutral revision code; selects level-sensitive early behaviour when revision equals it
   localparam logic [15:0] REV_EARLY = 16'h5A3C;
   localparam int INT_QUAL_CYCLES = 2;

   typedef enum logic [2:0] {
      CAUSE_NONE, CAUSE_RUN, CAUSE_EXT, CAUSE_DSI, CAUSE_ALIGN, CAUSE_ISI, CAUSE_OTHER
   } cause_t;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic [31:0] next_addr;
      logic is_branch;
      logic [31:0] branch_target;
      logic in_queue_bottom;
      logic clears_trace;
      logic other_exc;
   } retire_t;

   typedef struct packed {
      logic valid;
      logic [31:0] ea;
      logic reserve_op;
      logic cond_store;
      logic str_cmp_load;
      logic is_load;
      logic with_update;
      logic io_segment_flag;
      logic crosses_segment;
      logic misaligned;
   } mem_t;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic io_segment_flag;
      logic key_bit;
      logic [1:0] page_protection_bits;
   } fetch_t;

   typedef struct packed {
      logic take;
      cause_t cause;
      logic [31:0] vector;
      logic [31:0] saved_program_counter;
      logic [31:0] saved_state_register;
      logic [31:0] machine_state;
   } entry_t;
endpackage : exc_entry_pkg

// ===== rtl/int_qualifier.sv
`timescale 1ns/1ps
`default_nettype none
module int_qualifier (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Pin and mode
   input wire logic int_pin,
   input wire logic level_mode,
   // Qualified request
   output logic int_seen
);
   import exc_entry_pkg::*;
   logic sync1_q, sync1_d, sync2_q, sync2_d;
   logic [1:0] run_q, run_d;
   logic seen_q, seen_d;

   always_comb begin
      sync1_d = int_pin;
      sync2_d = sync1_q;
      run_d = run_q;
      if (!sync2_q) begin
         run_d = 2'h0;
      end else if (run_q != 2'(INT_QUAL_CYCLES)) begin
         run_d = run_q + 2'h1;
      end
      // Early parts see the raw synchronised level; the source must hold it
      if (level_mode) begin
         seen_d = sync2_q;
      end else begin
         seen_d = (run_d == 2'(INT_QUAL_CYCLES));
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         run_q <= 2'h0;
         seen_q <= 1'b0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         run_q <= run_d;
         seen_q <= seen_d;
      end
   end

   assign int_seen = seen_q;
endmodule : int_qualifier
`default_nettype wire

// ===== rtl/run_mode_trace_exception_entry.sv
`timescale 1ns/1ps
`default_nettype none
module run_mode_trace_exception_entry (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Configuration
   input wire logic [31:0] debug_mode_config,
   input wire logic [31:0] breakpoint_address,
   input wire logic [15:0] revision,
   // Machine state write from the core
   input wire logic ms_write,
   input wire logic [31:0] ms_write_data,
   // Pipeline events
   input wire exc_entry_pkg::retire_t retire,
   input wire exc_entry_pkg::mem_t mem,
   input wire exc_entry_pkg::fetch_t fetch,
   // Reservation control
   input wire logic reserve_set,
   input wire logic [31:0] reserve_addr,
   input wire logic cond_store_done,
   input wire logic snoop_store,
   input wire logic [31:0] snoop_addr,
   // External interrupt pin
   input wire logic ext_int_pin,
   // Exception entry
   output exc_entry_pkg::entry_t entry,
   output logic [31:0] saved_program_counter,
   output logic [31:0] saved_state_register,
   output logic [31:0] machine_state,
   output logic [31:0] fault_data_address,
   output logic reservation_valid,
   output logic fetch_allowed,
   output logic target_write
);
   import exc_entry_pkg::*;

   // ==================================================================
   // Interrupt qualification
   logic int_seen;

   int_qualifier u_int_qual (
      .clock(clock),
      .sys_rst(sys_rst),
      .int_pin(ext_int_pin),
      .level_mode(revision == REV_EARLY),
      .int_seen(int_seen)
   );

   // ==================================================================
   // Run mode decode
   // Machine state is read by the trace decode, so it is declared ahead of it
   logic [31:0] machine_state_q, machine_state_d;
   logic run_enabled;
   logic [2:0] run_mode;
   logic addr_hit, branch_hit, step_hit, trace_hit, run_hit;

   always_comb begin
      run_enabled = debug_mode_config[CFG_EN_HI:CFG_EN_LO] == RUN_EXC_ENABLED;
      run_mode = debug_mode_config[CFG_MODE_HI:CFG_MODE_LO];
      addr_hit = 1'b0;
      branch_hit = 1'b0;
      step_hit = 1'b0;
      // Undefined codes behave as normal run
      case (run_mode)
         MODE_LIMITED_IA, MODE_FULL_IA: begin
            addr_hit = retire.in_queue_bottom && retire.addr == breakpoint_address;
         end
         MODE_BRANCH: begin
            branch_hit = retire.is_branch && retire.branch_target == breakpoint_address;
         end
         MODE_STEP: begin
            step_hit = 1'b1;
         end
         default: begin
            addr_hit = 1'b0;
         end
      endcase
      // Trace follows the live bit, so clearing it takes effect next instruction
      trace_hit = machine_state_q[MS_STEP_EN] && !retire.clears_trace && !retire.other_exc;
      run_hit = retire.valid && run_enabled
         && (addr_hit || branch_hit || step_hit || trace_hit);
   end

   // ==================================================================
   // Fault detection
   logic isi_hit, dsi_hit, align_hit, io_special;

   always_comb begin
      // Read forbidden when key set and protection 00, or key clear never forbids
      isi_hit = fetch.valid && (fetch.io_segment_flag
         || (fetch.key_bit && fetch.page_protection_bits == 2'h0));
      io_special = mem.io_segment_flag
         && (mem.reserve_op || mem.cond_store || mem.str_cmp_load);
      align_hit = mem.valid && (mem.misaligned
         || (io_special && mem.crosses_segment));
      dsi_hit = mem.valid && io_special && !mem.crosses_segment;
   end

   assign fetch_allowed = !isi_hit;
   // Target register still written for I/O segment loads and updates
   assign target_write = mem.valid && (mem.is_load || mem.with_update)
      && (mem.io_segment_flag || !(dsi_hit || align_hit));

   // ==================================================================
   // Exception entry state
   logic [31:0] spc_q, spc_d, sst_q, sst_d, fda_q, fda_d;
   logic resv_q, resv_d;
   logic [31:0] resv_addr_q, resv_addr_d;
   entry_t entry_q, entry_d;
   cause_t cause;
   logic [31:0] base;

   always_comb begin
      // Priority: instruction fetch fault, alignment, data access, run mode, interrupt
      if (isi_hit) begin
         cause = CAUSE_ISI;
      end else if (align_hit) begin
         cause = CAUSE_ALIGN;
      end else if (dsi_hit) begin
         cause = CAUSE_DSI;
      end else if (run_hit) begin
         cause = CAUSE_RUN;
      end else if (int_seen && machine_state_q[MS_EXT_EN] && retire.valid) begin
         cause = CAUSE_EXT;
      end else if (retire.valid && retire.other_exc) begin
         cause = CAUSE_OTHER;
      end else begin
         cause = CAUSE_NONE;
      end
      base = machine_state_q[MS_VEC_HI] ? VEC_BASE_HI : VEC_BASE_LO;
      machine_state_d = ms_write ? ms_write_data : machine_state_q;
      // An instruction that drops the trace bit must stop tracing of the next one
      if (retire.valid && retire.clears_trace) begin
         machine_state_d[MS_STEP_EN] = 1'b0;
      end
      spc_d = spc_q;
      sst_d = sst_q;
      fda_d = fda_q;
      entry_d = '0;
      entry_d.cause = cause;
      case (cause)
         CAUSE_RUN: begin
            entry_d.vector = base | VEC_RUN_MODE;
            spc_d = retire.addr;
            sst_d = machine_state_q;
         end
         CAUSE_ISI: begin
            entry_d.vector = base | VEC_ISI;
            spc_d = fetch.addr;
            sst_d = machine_state_q;
            if (fetch.io_segment_flag) begin
               sst_d = machine_state_q & SAVE_HI_CLEAR;
            end
         end
         CAUSE_ALIGN: begin
            entry_d.vector = base | VEC_ALIGN;
            spc_d = retire.addr;
            sst_d = machine_state_q;
            fda_d = mem.ea;
         end
         CAUSE_DSI: begin
            entry_d.vector = base | VEC_DSI;
            spc_d = retire.addr;
            sst_d = machine_state_q;
            fda_d = mem.ea;
         end
         CAUSE_EXT, CAUSE_OTHER: begin
            entry_d.vector = base | (cause == CAUSE_EXT ? VEC_EXT : VEC_OTHER);
            spc_d = retire.next_addr;
            sst_d = machine_state_q;
         end
         default: begin
            entry_d.vector = '0;
         end
      endcase
      if (cause != CAUSE_NONE) begin
         entry_d.take = 1'b1;
         // Interrupt, trace, privilege, float and translation bits drop;
         // vector base and machine check survive
         machine_state_d = machine_state_q & ~((32'h1 << MS_EXT_EN) | (32'h1 << MS_STEP_EN)
            | (32'h1 << MS_PRIV) | (32'h1 << MS_FEX_HI) | (32'h1 << MS_FEX_LO)
            | (32'h1 << MS_FLT_AVAIL) | (32'h1 << MS_ITRANS) | (32'h1 << MS_DTRANS));
      end
      entry_d.saved_program_counter = spc_d;
      entry_d.saved_state_register = sst_d;
      entry_d.machine_state = machine_state_d;
   end

   // ==================================================================
   // Reservation
   always_comb begin
      resv_d = resv_q;
      resv_addr_d = resv_addr_q;
      if (reserve_set) begin
         resv_d = 1'b1;
         resv_addr_d = reserve_addr;
      end
      // Loss wins over a same-cycle set so a racing exception never leaves it live
      if (cond_store_done) begin
         resv_d = 1'b0;
      end
      if (snoop_store && (snoop_addr & SECTOR_MASK) == (resv_addr_q & SECTOR_MASK)) begin
         resv_d = 1'b0;
      end
      if (cause != CAUSE_NONE) begin
         resv_d = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         machine_state_q <= '0;
         spc_q <= '0;
         sst_q <= '0;
         fda_q <= '0;
         resv_q <= 1'b0;
         resv_addr_q <= '0;
         entry_q <= '0;
      end else begin
         machine_state_q <= machine_state_d;
         spc_q <= spc_d;
         sst_q <= sst_d;
         fda_q <= fda_d;
         resv_q <= resv_d;
         resv_addr_q <= resv_addr_d;
         entry_q <= entry_d;
      end
   end

   assign entry = entry_q;
   assign saved_program_counter = spc_q;
   assign saved_state_register = sst_q;
   assign machine_state = machine_state_q;
   assign fault_data_address = fda_q;
   assign reservation_valid = resv_q;
endmodule : run_mode_trace_exception_entry
`default_nettype wire

// ===== test/int_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module int_source_model (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Request from the bench
   input wire logic fire,
   input wire logic [3:0] hold,
   input wire logic level,
   input wire logic serviced,
   // Interrupt line
   output logic ext_int_pin
);
   logic held_q = 1'b0;
   logic glitch = 1'b0;
   logic [3:0] left_q = 4'h0;
   assign ext_int_pin = held_q | glitch;
   // A zero hold asks for a pulse that falls between two edges
   always @(posedge clock) begin
      if (fire && hold == 4'h0 && !level) begin
         #1 glitch = 1'b1;
         #2 glitch = 1'b0;
      end
   end
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         held_q <= 1'b0;
         left_q <= 4'h0;
      end else if (fire && (hold != 4'h0 || level)) begin
         held_q <= 1'b1;
         left_q <= hold;
      end else if (level) begin
         if (serviced) held_q <= 1'b0;
      end else if (left_q > 4'h1) begin
         left_q <= left_q - 4'h1;
      end else begin
         held_q <= 1'b0;
      end
   end
endmodule : int_source_model
`default_nettype wire

// ===== test/run_mode_trace_exception_entry_chk.sv
`timescale 1ns/1ps
`default_nettype none
module run_mode_trace_exception_entry_chk (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Inputs watched
   input wire logic [31:0] debug_mode_config,
   input wire logic [31:0] breakpoint_address,
   input wire logic ms_write,
   input wire exc_entry_pkg::retire_t retire,
   input wire exc_entry_pkg::mem_t mem,
   input wire exc_entry_pkg::fetch_t fetch,
   // Outputs watched
   input wire exc_entry_pkg::entry_t entry,
   input wire logic [31:0] saved_program_counter,
   input wire logic [31:0] saved_state_register,
   input wire logic [31:0] machine_state,
   input wire logic [31:0] fault_data_address,
   input wire logic reservation_valid,
   input wire logic fetch_allowed
);
   import exc_entry_pkg::*;
   localparam logic [31:0] CLR = 32'h0000_ED30;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   wire run_t = entry.take && entry.cause == CAUSE_RUN;
   wire quiet = !mem.valid && !fetch.valid;
   wire [2:0] mode = debug_mode_config[CFG_MODE_HI:CFG_MODE_LO];
   wire en_ok = debug_mode_config[CFG_EN_HI:CFG_EN_LO] == RUN_EXC_ENABLED;
   wire [31:0] vbase = (entry.machine_state[MS_VEC_HI] ? VEC_BASE_HI : VEC_BASE_LO)
      | VEC_RUN_MODE;
   // ==========
   // Sequences
   sequence s_bp_hit;
      retire.valid && retire.in_queue_bottom && retire.addr == breakpoint_address
         && mode == MODE_FULL_IA && en_ok && quiet;
   endsequence
   sequence s_trace_off;
      retire.valid && retire.clears_trace && !ms_write ##1
         retire.valid && !ms_write && quiet && mode == MODE_NORMAL;
   endsequence
   // ==========
   // Assertions
   a_vec_run:
      assert property (run_t |-> entry.vector == vbase)
      else $error("run vector wrong");
   a_msr_clear:
      assert property (run_t |-> (entry.machine_state & CLR) == 32'h0
         && entry.machine_state[MS_VEC_HI] == entry.saved_state_register[MS_VEC_HI]
         && entry.machine_state[MS_MCHK_EN] == entry.saved_state_register[MS_MCHK_EN])
      else $error("entry state bits wrong");
   a_state_copy:
      assert property (run_t && $past(!ms_write) |-> entry.saved_state_register == $past(machine_state))
      else $error("saved state not a copy");
   a_pc_saved:
      assert property (run_t && !$past(machine_state[MS_STEP_EN])
         |-> saved_program_counter == $past(retire.addr))
      else $error("saved pc wrong");
   a_bp_take:
      assert property (s_bp_hit |=> run_t)
      else $error("breakpoint missed");
   a_run_gate:
      assert property (run_t |-> $past(en_ok))
      else $error("run taken while disabled");
   a_trace_stop:
      assert property (s_trace_off |=> !run_t)
      else $error("trace after clear");
   a_resv_drop:
      assert property (entry.take |-> !reservation_valid)
      else $error("reservation survived");
   a_fault_addr:
      assert property (entry.take && entry.cause == CAUSE_ALIGN
         |-> fault_data_address == $past(mem.ea))
      else $error("fault address wrong");
   a_isi_block:
      assert property (fetch.valid && fetch.key_bit && fetch.page_protection_bits == 2'h0
         |-> !fetch_allowed ##1 entry.take && entry.cause == CAUSE_ISI)
      else $error("forbidden fetch passed");
endmodule : run_mode_trace_exception_entry_chk
`default_nettype wire

// ===== test/run_mode_trace_exception_entry_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module run_mode_trace_exception_entry_tb_top;
   import exc_entry_pkg::*;
   localparam logic [31:0] CLR = 32'h0000_ED30;
   // ==========
   // Signals
   logic clock = 0, sys_rst = 1, ms_write = 0, reserve_set = 0, cond_store_done = 0;
   logic snoop_store = 0, fire = 0, lvl = 0, hit, svc;
   logic [31:0] debug_mode_config = 0, breakpoint_address = 0, ms_write_data = 0;
   logic [31:0] reserve_addr = 0, snoop_addr = 0, a, v, c;
   logic [15:0] revision = ~REV_EARLY;
   logic [3:0] hold = 0;
   retire_t retire = '0, r;
   mem_t mem = '0, mm;
   fetch_t fetch = '0, ft;
   entry_t entry;
   logic [31:0] saved_program_counter, saved_state_register, machine_state, fault_data_address;
   logic reservation_valid, fetch_allowed, target_write, ext_int_pin;
   int n_fail = 0, n_checks = 0, cyc = 0, hits;
   always #2.5 clock = ~clock;
   assign svc = entry.take && entry.cause == CAUSE_EXT;
   run_mode_trace_exception_entry dut (.clock, .sys_rst, .debug_mode_config,
      .breakpoint_address, .revision, .ms_write, .ms_write_data, .retire, .mem, .fetch,
      .reserve_set, .reserve_addr, .cond_store_done, .snoop_store, .snoop_addr, .ext_int_pin,
      .entry, .saved_program_counter, .saved_state_register, .machine_state,
      .fault_data_address, .reservation_valid, .fetch_allowed, .target_write);
   int_source_model u_src (.clock, .sys_rst, .fire, .hold, .level(lvl), .serviced(svc),
      .ext_int_pin);
   // ==========
   // Helpers
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic tick();
      @(posedge clock);
   endtask : tick
   task automatic set_ms(input logic [31:0] d);
      ms_write <= 1'b1;
      ms_write_data <= d;
      tick();
      ms_write <= 1'b0;
      tick();
   endtask : set_ms
   // One event per edge; outputs read once the registering edge has landed
   task automatic fire_ev(input retire_t rr, input mem_t m, input fetch_t f);
      retire <= rr;
      mem <= m;
      fetch <= f;
      tick();
      retire <= '0;
      mem <= '0;
      fetch <= '0;
      #1;
   endtask : fire_ev
   function automatic retire_t mk_rt(input logic [31:0] x);
      return '{valid: 1, addr: x, next_addr: x + 4, is_branch: 1, branch_target: x,
         in_queue_bottom: 1, default: 0};
   endfunction : mk_rt
   function automatic logic [31:0] vec(input logic [31:0] s);
      return (s[MS_VEC_HI] ? VEC_BASE_HI : VEC_BASE_LO) | VEC_RUN_MODE;
   endfunction : vec
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         close_out();
      end
   end
   // ==========
   // Scenarios
   initial begin
      void'($urandom(32'hF4E0C079));
      repeat (5) tick();
      sys_rst <= 1'b0;
      for (int m = 0; m < 16; m++) begin
         a = $urandom;
         v = $urandom;
         v[MS_STEP_EN] = 1'b0;
         v[MS_EXT_EN] = 1'b0;
         c = '0;
         c[CFG_MODE_HI:CFG_MODE_LO] = m[2:0];
         c[CFG_EN_HI:CFG_EN_LO] = m[3] ? RUN_EXC_ENABLED : 2'h2;
         hit = m[3] && m[2:0] inside {MODE_LIMITED_IA, MODE_STEP, MODE_FULL_IA, MODE_BRANCH};
         debug_mode_config <= c;
         breakpoint_address <= a;
         reserve_addr <= a;
         reserve_set <= 1'b1;
         set_ms(v);
         reserve_set <= 1'b0;
         fire_ev(mk_rt(a), '0, '0);
         chk("take", hit, entry.take);
         chk("resv", !hit, reservation_valid);
         if (hit) begin
            chk("cause", CAUSE_RUN, entry.cause);
            chk("vector", vec(v), entry.vector);
            chk("spc", a, saved_program_counter);
            chk("sst", v, saved_state_register);
            chk("msr", v & ~CLR, machine_state);
         end
      end
      debug_mode_config <= 32'h0040_0000;
      v[MS_STEP_EN] = 1'b1;
      set_ms(v);
      fire_ev(mk_rt(~a), '0, '0);
      chk("trace", 1, entry.take && entry.cause == CAUSE_RUN);
      set_ms(v);
      r = mk_rt(a);
      r.clears_trace = 1'b1;
      retire <= r;
      tick();
      fire_ev(mk_rt(a + 4), '0, '0);
      chk("trace_off", 0, entry.take);
      reserve_set <= 1'b1;
      tick();
      reserve_set <= 1'b0;
      snoop_store <= 1'b1;
      snoop_addr <= (a & SECTOR_MASK) + 32'h20;
      tick();
      #1 chk("resv_keep", 1, reservation_valid);
      snoop_addr <= a ^ ($urandom & 32'h1F);
      tick();
      snoop_store <= 1'b0;
      #1 chk("resv_drop", 0, reservation_valid);
      for (int k = 0; k < 6; k++) begin
         mm = '{valid: 1, ea: a + k, io_segment_flag: 1, crosses_segment: k > 2, default: 0};
         mm.reserve_op = k % 3 == 0;
         mm.cond_store = k % 3 == 1;
         mm.str_cmp_load = k % 3 == 2;
         fire_ev('0, mm, '0);
         chk("cause", k > 2 ? CAUSE_ALIGN : CAUSE_DSI, entry.cause);
         if (k > 2) chk("dar", a + k, fault_data_address);
      end
      mem <= '{valid: 1, ea: a, is_load: 1, with_update: 1, io_segment_flag: 1, default: 0};
      #1 chk("tgt_wr", 1, target_write);
      mem <= '0;
      for (int k = 0; k < 3; k++) begin
         ft = '{valid: 1, addr: a, key_bit: k == 0, io_segment_flag: k == 1,
            page_protection_bits: k == 0 ? 2'h0 : 2'h2, default: 0};
         fetch <= ft;
         #1 chk("fetch_ok", k == 2, fetch_allowed);
         fire_ev('0, '0, ft);
         chk("isi", k < 2, entry.take && entry.cause == CAUSE_ISI);
         if (k == 1) chk("sst_hi", 0, saved_state_register[31:16]);
      end
      debug_mode_config <= '0;
      for (int j = 0; j < 3; j++) begin
         revision <= j == 2 ? REV_EARLY : ~REV_EARLY;
         lvl <= j == 2;
         hold <= j == 0 ? 4'h0 : 4'h2;
         v[MS_STEP_EN] = 1'b0;
         v[MS_EXT_EN] = 1'b1;
         set_ms(v);
         fire <= 1'b1;
         tick();
         fire <= 1'b0;
         hits = 0;
         repeat (12) begin
            retire <= mk_rt($urandom);
            tick();
            #1 if (entry.take === 1'b1 && entry.cause === CAUSE_EXT) hits++;
         end
         retire <= '0;
         chk("ext_hits", j > 0, hits);
      end
      close_out();
   end
endmodule : run_mode_trace_exception_entry_tb_top
bind run_mode_trace_exception_entry run_mode_trace_exception_entry_chk u_chk (.clock,
   .sys_rst, .debug_mode_config, .breakpoint_address, .ms_write, .retire, .mem, .fetch,
   .entry, .saved_program_counter, .saved_state_register, .machine_state,
   .fault_data_address, .reservation_valid, .fetch_allowed);
`default_nettype wire
